// >>> core/lop_exec.sv
/*
  Execution block for the NAND, NOR and OR instructions and for the
  indirect-pointer load, with bank protection, a status/mask interrupt and a
  plain strobe register port.
  Assumes the register file answers the two read addresses in the same cycle,
  instruction words arrive on clk_sys, and software drives the register port
  on clk_sys with one-cycle strobes.
*/
// Strobed register access and the register addresses were chosen for this implementation.
module lop_exec
(
  input  wire logic                            clk_sys,
  input  wire logic                            rstn,
  // Instruction issue
  input  wire logic                            instr_valid,
  input  wire logic [lop_pkg::DATA_W-1:0]      instr_word,
  // Register file read ports
  output logic [lop_pkg::REGNUM_W-1:0]         rf_addr_first,
  output logic [lop_pkg::REGNUM_W-1:0]         rf_addr_second,
  input  wire logic [lop_pkg::DATA_W-1:0]      rf_data_first,
  input  wire logic [lop_pkg::DATA_W-1:0]      rf_data_second,
  // Result write-back
  output logic                                 result_valid,
  output logic [lop_pkg::REGNUM_W-1:0]         result_target,
  output logic [lop_pkg::DATA_W-1:0]           result_data,
  // Condition flags
  output logic                                 flag_n,
  output logic                                 flag_z,
  output logic                                 flag_update,
  // Indirect pointers and trap
  output logic [lop_pkg::REGNUM_W-1:0]         first_indirect_pointer,
  output logic [lop_pkg::REGNUM_W-1:0]         second_indirect_pointer,
  output logic [lop_pkg::REGNUM_W-1:0]         result_indirect_pointer,
  output logic                                 prot_trap,
  // Register port
  input  wire logic [lop_pkg::ADDR_W-1:0]      reg_addr,
  input  wire logic [lop_pkg::DATA_W-1:0]      reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic [lop_pkg::DATA_W-1:0]           reg_rdata,
  // Interrupt
  output logic                                 irq
);
  import lop_pkg::*;

  // Field extraction, shared by decode and protection check
  function automatic logic [REGNUM_W-1:0] field_of(input logic [DATA_W-1:0] w,
                                                   input int unsigned lo);
    field_of = w[lo +: REGNUM_W];
  endfunction

  // Protection lookup for one absolute register number
  function automatic logic is_protected(input logic [REGNUM_W-1:0] regnum,
                                        input logic [BANK_W-1:0] prot);
    is_protected = prot[regnum[BANK_SEL_HI:BANK_SEL_LO]];
  endfunction

  // Decoded fields
  logic [OPC_W-1:0]    opcode;
  logic [REGNUM_W-1:0] fld_result;
  logic [REGNUM_W-1:0] fld_first;
  logic [REGNUM_W-1:0] fld_second;
  logic                lit_sel;
  lop_kind_e           kind;
  logic [DATA_W-1:0]   second_operand;
  logic [DATA_W-1:0]   lu_result;
  logic                lu_neg;
  logic                lu_zero;
  logic                any_protected;

  // Stage and pointer state
  logic                next_result_valid;
  logic [REGNUM_W-1:0] next_result_target;
  logic [DATA_W-1:0]   next_result_data;
  logic                next_flag_n;
  logic                next_flag_z;
  logic                next_flag_update;
  logic                next_prot_trap;
  logic                ptr_pending;
  logic                next_ptr_pending;
  logic [REGNUM_W-1:0] pend_first;
  logic [REGNUM_W-1:0] pend_second;
  logic [REGNUM_W-1:0] pend_result;
  logic [REGNUM_W-1:0] next_pend_first;
  logic [REGNUM_W-1:0] next_pend_second;
  logic [REGNUM_W-1:0] next_pend_result;
  logic [REGNUM_W-1:0] next_first_ptr;
  logic [REGNUM_W-1:0] next_second_ptr;
  logic [REGNUM_W-1:0] next_result_ptr;

  // Software registers
  logic                user_mode;
  logic                next_user_mode;
  logic [BANK_W-1:0]   bank_prot;
  logic [BANK_W-1:0]   next_bank_prot;
  logic [EV_W-1:0]     irq_stat;
  logic [EV_W-1:0]     next_irq_stat;
  logic [EV_W-1:0]     irq_mask;
  logic [EV_W-1:0]     next_irq_mask;
  logic [EV_W-1:0]     events;
  logic [DATA_W-1:0]   next_reg_rdata;

  // Instruction decode
  always_comb
  begin
    opcode     = instr_word[OPC_HI:OPC_LO];
    fld_result = field_of(instr_word, RES_LO);
    fld_first  = field_of(instr_word, FST_LO);
    fld_second = field_of(instr_word, SND_LO);
    lit_sel    = opcode[LIT_SEL_BIT];
    case (opcode & OPC_BASE_MASK)
      OPC_NAND: kind = LOP_NAND;
      OPC_NOR:  kind = LOP_NOR;
      OPC_OR:   kind = LOP_OR;
      OPC_LOAD_PTRS: kind = lit_sel ? LOP_NONE : LOP_LOAD_PTRS;
      default:  kind = LOP_NONE;
    endcase
  end

  // Register file addressing and second operand selection
  assign rf_addr_first  = fld_first;
  assign rf_addr_second = fld_second;
  assign second_operand = lit_sel ? {{(DATA_W-LIT_W){1'b0}}, fld_second}
                                  : rf_data_second;

  // Bitwise function unit
  lop_logic_unit u_logic
  (
    .kind           (kind),
    .first_operand  (rf_data_first),
    .second_operand (second_operand),
    .result         (lu_result),
    .neg            (lu_neg),
    .zero           (lu_zero)
  );

  // Protection check over the three absolute register numbers
  assign any_protected = is_protected(fld_first, bank_prot)
                       | is_protected(fld_second, bank_prot)
                       | is_protected(fld_result, bank_prot);

  // Execute stage: results, flags, trap and pointer staging
  always_comb
  begin
    next_result_valid  = 1'b0;
    next_result_target = result_target;
    next_result_data   = result_data;
    next_flag_n        = flag_n;
    next_flag_z        = flag_z;
    next_flag_update   = 1'b0;
    next_prot_trap     = 1'b0;
    next_ptr_pending   = 1'b0;
    next_pend_first    = pend_first;
    next_pend_second   = pend_second;
    next_pend_result   = pend_result;
    next_first_ptr     = first_indirect_pointer;
    next_second_ptr    = second_indirect_pointer;
    next_result_ptr    = result_indirect_pointer;
    events             = RST_EV;
    // Staged pointer values land one cycle after the load
    if (ptr_pending)
    begin
      next_first_ptr  = pend_first;
      next_second_ptr = pend_second;
      next_result_ptr = pend_result;
    end
    if (instr_valid)
    begin
      case (kind)
        LOP_NAND, LOP_NOR, LOP_OR:
        begin
          next_result_valid  = 1'b1;
          next_result_target = fld_result;
          next_result_data   = lu_result;
          next_flag_n        = lu_neg;
          next_flag_z        = lu_zero;
          next_flag_update   = 1'b1;
        end
        LOP_LOAD_PTRS:
        begin
          if (user_mode && any_protected)
          begin
            next_prot_trap      = 1'b1;
            events[EV_PROT]     = 1'b1;
          end
          else
          begin
            next_ptr_pending    = 1'b1;
            next_pend_first     = fld_first;
            next_pend_second    = fld_second;
            next_pend_result    = fld_result;
            events[EV_PTR_LOAD] = 1'b1;
          end
        end
        default:
        begin
          events[EV_BAD_OPC] = 1'b1;
        end
      endcase
    end
  end

  // Execute stage registers
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      result_valid            <= 1'b0;
      result_target           <= RST_REGNUM;
      result_data             <= RST_DATA;
      flag_n                  <= 1'b0;
      flag_z                  <= 1'b0;
      flag_update             <= 1'b0;
      prot_trap               <= 1'b0;
      ptr_pending             <= 1'b0;
      pend_first              <= RST_REGNUM;
      pend_second             <= RST_REGNUM;
      pend_result             <= RST_REGNUM;
      first_indirect_pointer  <= RST_REGNUM;
      second_indirect_pointer <= RST_REGNUM;
      result_indirect_pointer <= RST_REGNUM;
    end
    else
    begin
      result_valid            <= next_result_valid;
      result_target           <= next_result_target;
      result_data             <= next_result_data;
      flag_n                  <= next_flag_n;
      flag_z                  <= next_flag_z;
      flag_update             <= next_flag_update;
      prot_trap               <= next_prot_trap;
      ptr_pending             <= next_ptr_pending;
      pend_first              <= next_pend_first;
      pend_second             <= next_pend_second;
      pend_result             <= next_pend_result;
      first_indirect_pointer  <= next_first_ptr;
      second_indirect_pointer <= next_second_ptr;
      result_indirect_pointer <= next_result_ptr;
    end
  end

  // Register port: writes, sticky status with set winning over clear, reads
  always_comb
  begin
    next_user_mode = user_mode;
    next_bank_prot = bank_prot;
    next_irq_mask  = irq_mask;
    next_irq_stat  = irq_stat;
    next_reg_rdata = RST_DATA;
    if (reg_wr)
    begin
      case (reg_addr)
        REG_CTRL:      next_user_mode = reg_wdata[CTRL_USER_BIT];
        REG_BANK_PROT: next_bank_prot = reg_wdata[BANK_W-1:0];
        REG_IRQ_STAT:  next_irq_stat  = irq_stat & ~reg_wdata[EV_W-1:0];
        REG_IRQ_MASK:  next_irq_mask  = reg_wdata[EV_W-1:0];
        default:       next_user_mode = user_mode;
      endcase
    end
    next_irq_stat = next_irq_stat | events;  // New events beat a same-cycle clear
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL:      next_reg_rdata[CTRL_USER_BIT] = user_mode;
        REG_BANK_PROT: next_reg_rdata[BANK_W-1:0]    = bank_prot;
        REG_IRQ_STAT:  next_reg_rdata[EV_W-1:0]      = irq_stat;
        REG_IRQ_MASK:  next_reg_rdata[EV_W-1:0]      = irq_mask;
        REG_POINTERS:
        begin
          next_reg_rdata[PTR_FST_LO +: REGNUM_W] = first_indirect_pointer;
          next_reg_rdata[PTR_SND_LO +: REGNUM_W] = second_indirect_pointer;
          next_reg_rdata[PTR_RES_LO +: REGNUM_W] = result_indirect_pointer;
        end
        REG_FLAGS:
        begin
          next_reg_rdata[FLAG_Z_BIT] = flag_z;
          next_reg_rdata[FLAG_N_BIT] = flag_n;
        end
        default:       next_reg_rdata = RST_DATA;  // Unmapped reads return zero
      endcase
    end
  end

  // Register port state
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      user_mode <= 1'b0;
      bank_prot <= RST_BANK;
      irq_stat  <= RST_EV;
      irq_mask  <= RST_EV;
      reg_rdata <= RST_DATA;
    end
    else
    begin
      user_mode <= next_user_mode;
      bank_prot <= next_bank_prot;
      irq_stat  <= next_irq_stat;
      irq_mask  <= next_irq_mask;
      reg_rdata <= next_reg_rdata;
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign irq = |(irq_stat & irq_mask);

endmodule

// >>> shared/lop_pkg.sv
/*
  Shared constants for the logical-operation and pointer-setup execution block:
  instruction field layout, opcodes, register offsets, field positions and
  reset values.
  Assumes a single 25 MHz core clock and a plain strobe register port.
*/
package lop_pkg;

  // Data and field widths
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned REGNUM_W = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned OPC_W    = 8;
  localparam int unsigned LIT_W    = 8;

  // Instruction word field positions
  localparam int unsigned OPC_HI   = 31;
  localparam int unsigned OPC_LO   = 24;
  localparam int unsigned RES_HI   = 23;
  localparam int unsigned RES_LO   = 16;
  localparam int unsigned FST_HI   = 15;
  localparam int unsigned FST_LO   = 8;
  localparam int unsigned SND_HI   = 7;
  localparam int unsigned SND_LO   = 0;
  localparam int unsigned LIT_SEL_BIT = 0;  // Lowest opcode bit selects the literal

  // Opcodes with the literal-select bit cleared
  localparam logic [OPC_W-1:0] OPC_NAND  = 8'h9A;
  localparam logic [OPC_W-1:0] OPC_NOR   = 8'h96;
  localparam logic [OPC_W-1:0] OPC_OR    = 8'h92;
  localparam logic [OPC_W-1:0] OPC_LOAD_PTRS = 8'h9E;
  localparam logic [OPC_W-1:0] OPC_BASE_MASK = 8'hFE;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] REG_BANK_PROT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK  = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_POINTERS  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_FLAGS     = 8'h14;

  // Control fields
  localparam int unsigned CTRL_USER_BIT = 0;

  // Register bank protection: one bit per bank of sixteen registers
  localparam int unsigned BANK_W     = 16;
  localparam int unsigned BANK_SEL_HI = 7;
  localparam int unsigned BANK_SEL_LO = 4;

  // Event bits of status and mask
  localparam int unsigned EV_W        = 3;
  localparam int unsigned EV_PROT     = 0;
  localparam int unsigned EV_PTR_LOAD = 1;
  localparam int unsigned EV_BAD_OPC  = 2;

  // Flag register fields
  localparam int unsigned FLAG_Z_BIT = 0;
  localparam int unsigned FLAG_N_BIT = 1;

  // Pointer register fields
  localparam int unsigned PTR_FST_LO = 0;
  localparam int unsigned PTR_SND_LO = 8;
  localparam int unsigned PTR_RES_LO = 16;

  // Reset values
  localparam logic [DATA_W-1:0]   RST_DATA   = 32'h0000_0000;
  localparam logic [BANK_W-1:0]   RST_BANK   = 16'h0000;
  localparam logic [EV_W-1:0]     RST_EV     = 3'h0;
  localparam logic [REGNUM_W-1:0] RST_REGNUM = 8'h00;

  // Operation kinds for the logic unit and the decoder
  typedef enum logic [2:0] {
    LOP_NONE,
    LOP_NAND,
    LOP_NOR,
    LOP_OR,
    LOP_LOAD_PTRS
  } lop_kind_e;

endpackage

// >>> core/lop_logic_unit.sv
/*
  Bitwise logic unit: NAND, NOR and OR of two 32-bit operands, with the
  negative and zero flags of the result.
  Purely combinational; the caller registers the outputs.
*/
module lop_logic_unit
(
  input  lop_pkg::lop_kind_e           kind,
  input  wire logic [lop_pkg::DATA_W-1:0] first_operand,
  input  wire logic [lop_pkg::DATA_W-1:0] second_operand,
  output logic [lop_pkg::DATA_W-1:0]   result,
  output logic                         neg,
  output logic                         zero
);
  import lop_pkg::*;

  // Function select and flag derivation
  always_comb
  begin
    case (kind)
      LOP_NAND: result = ~(first_operand & second_operand);
      LOP_NOR:  result = ~(first_operand | second_operand);
      LOP_OR:   result = first_operand | second_operand;
      default:  result = RST_DATA;
    endcase
    neg  = result[DATA_W-1];
    zero = (result == RST_DATA);
  end

endmodule

// >>> tb/lop_exec_monitor.sv
/*
  Checker for lop_exec: logic results, flags, pointer load, protection trap.
  Assumes it is bound to lop_exec and sees only that module's ports.
*/
module lop_exec_monitor
(
  input wire logic                         clk_sys,
  input wire logic                         rstn,
  input wire logic                         instr_valid,
  input wire logic [lop_pkg::DATA_W-1:0]   instr_word,
  input wire logic [lop_pkg::DATA_W-1:0]   rf_data_first,
  input wire logic [lop_pkg::DATA_W-1:0]   rf_data_second,
  input wire logic                         result_valid,
  input wire logic [lop_pkg::REGNUM_W-1:0] result_target,
  input wire logic [lop_pkg::DATA_W-1:0]   result_data,
  input wire logic                         flag_n,
  input wire logic                         flag_z,
  input wire logic                         flag_update,
  input wire logic [lop_pkg::REGNUM_W-1:0] first_indirect_pointer,
  input wire logic [lop_pkg::REGNUM_W-1:0] second_indirect_pointer,
  input wire logic [lop_pkg::REGNUM_W-1:0] result_indirect_pointer,
  input wire logic                         prot_trap
);
  timeunit 1ns;
  timeprecision 100ps;
  import lop_pkg::*;
  logic [OPC_W-1:0] opc;
  logic             go_logic;
  logic             go_load;
  logic [23:0]      ptrs;
  logic [23:0]      want;
  // Decoded view of the issued word and of the pointer outputs
  assign opc      = instr_word[OPC_HI:OPC_LO];
  assign go_logic = instr_valid && ((opc & OPC_BASE_MASK) inside {OPC_NAND, OPC_NOR, OPC_OR});
  assign go_load  = instr_valid && opc == OPC_LOAD_PTRS;
  assign ptrs     = {result_indirect_pointer, second_indirect_pointer, first_indirect_pointer};
  assign want     = {instr_word[RES_HI:RES_LO],
                     instr_word[SND_HI:SND_LO],
                     instr_word[FST_HI:FST_LO]};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_logic_strobe:
    assert property (go_logic |=> result_valid && flag_update) else $error("no write-back");
  a_target_field:
    assert property (go_logic |=> result_target == $past(instr_word[RES_HI:RES_LO]))
    else $error("wrong target");
  a_nand_value:
    assert property (go_logic && opc == OPC_NAND |=>
      result_data == ~($past(rf_data_first) & $past(rf_data_second))) else $error("bad nand");
  a_nor_literal:
    assert property (go_logic && opc == (OPC_NOR | 8'h01) |=> result_data ==
      ~($past(rf_data_first) | {24'h000000, $past(instr_word[SND_HI:SND_LO])}))
    else $error("bad nor");
  a_or_value:
    assert property (go_logic && opc == OPC_OR |=>
      result_data == ($past(rf_data_first) | $past(rf_data_second))) else $error("bad or");
  a_flag_value:
    assert property (flag_update |-> flag_n == result_data[DATA_W-1] &&
      flag_z == (result_data == 32'h0)) else $error("bad flags");
  a_flag_hold:
    assert property (!flag_update |-> $stable({flag_n, flag_z})) else $error("flags moved");
  a_ptr_delayed:
    assert property (go_load && !$past(instr_valid) |=> $stable(ptrs))
    else $error("pointers too early");
  a_ptr_load:
    assert property (go_load ##1 !prot_trap |=> ptrs == $past(want, 2))
    else $error("bad pointers");
  a_trap_keeps:
    assert property (prot_trap |-> !flag_update && !result_valid ##1 $stable(ptrs))
    else $error("trap changed state");
  a_trap_cause:
    assert property (prot_trap |-> $past(go_load)) else $error("stray trap");
  // Main scenarios reached
  cover property (go_load ##1 prot_trap);
  cover property (go_logic && opc[LIT_SEL_BIT]);
  cover property (flag_update && flag_z);
endmodule

// >>> tb/lop_exec_bench.sv
/*
  Self-checking bench for lop_exec: logic results and flags, delayed pointer
  load, protection trap, status and mask registers.
  Assumes a register file in which register k holds k in every byte.
*/
module lop_exec_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import lop_pkg::*;
  logic                clk_sys = 1'b0;
  logic                rstn = 1'b0;
  logic                instr_valid = 1'b0;
  logic [DATA_W-1:0]   instr_word = 32'h0;
  logic [REGNUM_W-1:0] rf_addr_first;
  logic [REGNUM_W-1:0] rf_addr_second;
  logic [DATA_W-1:0]   rf_data_first;
  logic [DATA_W-1:0]   rf_data_second;
  logic                result_valid;
  logic [REGNUM_W-1:0] result_target;
  logic [DATA_W-1:0]   result_data;
  logic                flag_n;
  logic                flag_z;
  logic                flag_update;
  logic [REGNUM_W-1:0] first_indirect_pointer;
  logic [REGNUM_W-1:0] second_indirect_pointer;
  logic [REGNUM_W-1:0] result_indirect_pointer;
  logic                prot_trap;
  logic [ADDR_W-1:0]   reg_addr = 8'h0;
  logic [DATA_W-1:0]   reg_wdata = 32'h0;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [DATA_W-1:0]   reg_rdata;
  logic                irq;
  logic [23:0]         ptrs;
  int                  errors = 0;
  int                  checks = 0;
  // 25 MHz clock and a register file that answers in the same cycle
  always #20 clk_sys = ~clk_sys;
  assign rf_data_first  = {4{rf_addr_first}};
  assign rf_data_second = {4{rf_addr_second}};
  assign ptrs = {result_indirect_pointer, second_indirect_pointer, first_indirect_pointer};
  lop_exec dut
  (
    .clk_sys, .rstn, .instr_valid, .instr_word, .rf_addr_first, .rf_addr_second,
    .rf_data_first, .rf_data_second, .result_valid, .result_target, .result_data,
    .flag_n, .flag_z, .flag_update, .first_indirect_pointer, .second_indirect_pointer,
    .result_indirect_pointer, .prot_trap, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq
  );
  // Compares a seen value with the expected one
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Register port cycles and instruction issue
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic issue(input logic [DATA_W-1:0] w);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word  <= w;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  // Reset values of the outputs
  task automatic t_reset();
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    chk({ptrs, irq, result_valid, prot_trap}, 32'h0);
    rchk(REG_FLAGS, 32'h0);
  endtask
  // Every logic opcode in register and literal form, with the flags
  task automatic t_logic();
    logic [DATA_W-1:0] w [6] = '{32'h9A03FFFF, 32'h9B04F00F, 32'h96051234,
                                 32'h92078142, 32'h93080180, 32'h97060000};
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [DATA_W-1:0] e;
    foreach (w[i])
    begin
      a = {4{w[i][15:8]}};
      b = w[i][24] ? {24'h000000, w[i][7:0]} : {4{w[i][7:0]}};
      case (w[i][31:24] & OPC_BASE_MASK)
        OPC_NAND: e = ~(a & b);
        OPC_NOR:  e = ~(a | b);
        default:  e = a | b;
      endcase
      issue(w[i]);
      chk({rf_addr_first, rf_addr_second}, w[i][15:0]);
      chk({result_valid, flag_update, result_target}, {2'h3, w[i][23:16]});
      chk(result_data, e);
      chk({flag_n, flag_z}, {e[31], e == 32'h0});
    end
  endtask
  // Supervisor pointer load: delay, field mapping, flags kept, event raised
  task automatic t_load();
    wr(REG_IRQ_MASK, 32'h2);
    issue(32'h9E214365);
    chk({prot_trap, result_valid}, 32'h0);
    chk(ptrs, 24'h0);
    step();
    chk(ptrs, 24'h216543);
    chk({flag_n, flag_z}, 2'h2);
    chk(irq, 1'b1);
    rchk(REG_POINTERS, 32'h00216543);
    wr(REG_IRQ_STAT, 32'h2);
    step();
    chk(irq, 1'b0);
  endtask
  // User-mode load of a protected register traps; unprotected one loads
  task automatic t_trap();
    logic [DATA_W-1:0] d;
    wr(REG_CTRL, 32'h1);
    wr(REG_BANK_PROT, 32'h4);
    wr(REG_IRQ_MASK, 32'h1);
    issue(32'h9E506025);
    chk({prot_trap, result_valid}, 32'h2);
    step();
    chk(ptrs, 24'h216543);
    chk(irq, 1'b1);
    rd(REG_IRQ_STAT, d);
    chk(d & 32'h1, 32'h1);
    wr(REG_IRQ_MASK, 32'h0);
    step();
    chk(irq, 1'b0);
    issue(32'h9E010203);
    chk(prot_trap, 1'b0);
    step();
    chk(ptrs, 24'h010302);
    rchk(8'h40, 32'h0);
    issue(32'hFF000000);
    chk({result_valid, prot_trap}, 32'h0);
    rchk(REG_IRQ_STAT, 32'h7);
  endtask
  // Main sequence
  initial
  begin
    t_reset();
    t_logic();
    t_load();
    t_trap();
    results();
  end
  // Watchdog against a hang
  initial
  begin
    #40000;
    errors++;
    results();
  end
endmodule

bind lop_exec lop_exec_monitor mon
(
  .clk_sys, .rstn, .instr_valid, .instr_word, .rf_data_first, .rf_data_second,
  .result_valid, .result_target, .result_data, .flag_n, .flag_z, .flag_update,
  .first_indirect_pointer, .second_indirect_pointer, .result_indirect_pointer, .prot_trap
);
